//--- ccu_pkg.sv
// Shared constants of the capture/compare unit
package ccu_pkg;

	// Register indices; byte address on the bus is four times the index
	localparam logic [7:0] IDX_VALUE_LOW = 8'h13;
	localparam logic [7:0] IDX_VALUE_HIGH = 8'h14;
	localparam logic [7:0] IDX_UNIT_CONTROL = 8'h15;
	localparam logic [7:0] IDX_EVENT_STATUS = 8'h16;
	localparam logic [7:0] ADDR_VALUE_LOW = {IDX_VALUE_LOW[5:0], 2'b00};
	localparam logic [7:0] ADDR_VALUE_HIGH = {IDX_VALUE_HIGH[5:0], 2'b00};
	localparam logic [7:0] ADDR_UNIT_CONTROL = {IDX_UNIT_CONTROL[5:0], 2'b00};
	localparam logic [7:0] ADDR_EVENT_STATUS = {IDX_EVENT_STATUS[5:0], 2'b00};

	// Reset values
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] VALUE_RESET = 8'h00;

	// Field positions inside unit_control
	localparam int CTL_STEER_LSB = 6;
	localparam int CTL_DUTY_LSB = 4;
	localparam int CTL_MODE_LSB = 0;
	// Event flag position inside the status register
	localparam int STS_FLAG_BIT = 0;

	// Mode select codes
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_CMP_SET = 4'h8;
	localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
	localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;

	// Upper mode-bit groups
	localparam logic [1:0] GRP_CAPTURE = 2'h1;
	localparam logic [1:0] GRP_COMPARE = 2'h2;
	localparam logic [1:0] GRP_PWM = 2'h3;

	// Output steering codes
	localparam logic [1:0] STEER_SINGLE = 2'h0;
	localparam logic [1:0] STEER_FWD = 2'h1;
	localparam logic [1:0] STEER_HALF = 2'h2;
	localparam logic [1:0] STEER_REV = 2'h3;

	// Last prescaler count before a capture fires
	localparam logic [3:0] PRE4_LAST = 4'h3;
	localparam logic [3:0] PRE16_LAST = 4'hF;

endpackage

//--- ccu_top.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
// Notes on behaviour
// - The 16-bit value is two separately addressable byte registers, low and high.
// - Mode 1011 match sets flag, clears the timer and starts conversion if enabled.
// - The timer clear from a special event never sets the timer overflow flag.
// - Outside PWM modes steering is ignored: only compare modes claim a pin, output A alone.
// - In PWM modes steering picks single, forward, half or reverse bridge outputs.
// - Control bits 5:4 are the duty low bits; unused outside PWM.
// - Mode 0000 switches the unit off and resets its internal state.
// - Modes 0100 to 0111 capture on falling, rising, 4th or 16th rising edge.
// - Modes 0010, 1000, 1001 toggle, set or clear the output and set the flag.
// - Mode 1010 sets only the flag on a match; the pin stays unchanged.
// - Modes 11xx are PWM; bit 1 inverts A and C, bit 0 inverts B and D.
// - A capture event copies the full 16-bit timer count into both bytes.
// - Each capture sets the event flag; only software clears it.
// - A new capture overwrites the old value whether read or not.
// - A port write that changes the pin as an output counts as an edge.
// - The prescaler counter clears when off, outside capture, and on reset.
// - Switching prescalers directly keeps the prescaler count.
// - Compare checks every count; on match the latch and flag share one edge, pin A follows one edge later.
// - Writing zero to control forces the compare output latch low.
module ccu_top
	import ccu_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o,
	// Timer one interface, same clock domain
	input wire logic [15:0] timer_one_count_i,
	input wire logic timer_one_tick_i,
	output logic timer_one_clear_o,
	// Converter start
	input wire logic adc_enable_i,
	output logic adc_start_o,
	// Capture pin level as seen at the pad
	input wire logic capture_compare_pin_i,
	// Modulated waveform from the PWM timing engine
	input wire logic pwm_mod_i,
	output logic pwm_output_a_o,
	output logic pwm_output_b_o,
	output logic pwm_output_c_o,
	output logic pwm_output_d_o,
	output logic [3:0] pin_owned_o,
	output logic [9:0] duty_cycle_o,
	output logic unit_event_flag_o
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic sync3;
		logic pin_lvl;
		logic [3:0] pres;
		logic [7:0] val_lo;
		logic [7:0] val_hi;
		logic [7:0] ctl;
		logic flag;
		logic cmp_latch;
		logic tmr_clear;
		logic adc_start;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic out_a;
		logic out_b;
		logic out_c;
		logic out_d;
		logic [3:0] own;
		logic [9:0] duty;
	} ccu_state_s;

	ccu_state_s q;
	ccu_state_s next_q;

	logic [3:0] mode;
	logic [1:0] steer;
	logic is_cap;
	logic is_cmp;
	logic is_pwm;
	logic pin_stable;
	logic pin_rise;
	logic pin_fall;
	logic [3:0] pre_last;
	logic cap_fire;
	logic match;
	logic acc_done;
	logic wr_en;
	logic addr_ok;
	logic flag_clr;
	logic [3:0] drv;

	// Decoded mode groups
	assign mode = q.ctl[CTL_MODE_LSB +: 4];
	assign steer = q.ctl[CTL_STEER_LSB +: 2];
	assign is_cap = (mode[3:2] == GRP_CAPTURE);
	assign is_cmp = (mode == MODE_CMP_TOGGLE) || (mode[3:2] == GRP_COMPARE);
	assign is_pwm = (mode[3:2] == GRP_PWM);

	// Edges are taken only once the second and third stages agree, so a pin
	// that moves near a clock edge cannot produce a double event
	assign pin_stable = (q.sync2 == q.sync3);
	assign pin_rise = pin_stable && q.sync3 && !q.pin_lvl;
	assign pin_fall = pin_stable && !q.sync3 && q.pin_lvl;

	// Prescaler terminal count for the divided capture modes
	assign pre_last = (mode == MODE_CAP_RISE16) ? PRE16_LAST : PRE4_LAST;

	// A count left over from the previous prescaler may fire early
	always_comb begin
		cap_fire = 1'b0;
		if (is_cap) begin
			unique case (mode)
				MODE_CAP_FALL: cap_fire = pin_fall;
				MODE_CAP_RISE: cap_fire = pin_rise;
				default: cap_fire = pin_rise && (q.pres >= pre_last);
			endcase
		end
	end

	// The count is checked whenever timer one has just taken a new value
	assign match = is_cmp && timer_one_tick_i &&
		(timer_one_count_i == {q.val_hi, q.val_lo});

	// Bus decode; writes land at the edge that completes the access
	assign acc_done = psel_i && penable_i && q.pready;
	assign wr_en = ce_i && acc_done && pwrite_i && pstrb_i[0];
	assign addr_ok = (paddr_i == ADDR_VALUE_LOW) || (paddr_i == ADDR_VALUE_HIGH) ||
		(paddr_i == ADDR_UNIT_CONTROL) || (paddr_i == ADDR_EVENT_STATUS);
	assign flag_clr = wr_en && (paddr_i == ADDR_EVENT_STATUS) && pwdata_i[STS_FLAG_BIT];

	// Output drive levels before polarity, per steering code
	always_comb begin
		drv = 4'h0;
		unique case (steer)
			STEER_SINGLE: drv = {3'b000, pwm_mod_i};
			STEER_FWD: drv = {pwm_mod_i, 2'b00, 1'b1};
			STEER_HALF: drv = {2'b00, !pwm_mod_i, pwm_mod_i};
			STEER_REV: drv = {1'b0, 1'b1, pwm_mod_i, 1'b0};
		endcase
	end

	// Next-state logic; a low clock enable leaves every field as it is
	always_comb begin
		next_q = q;
		if (ce_i) begin
			// Pin synchroniser and settled level
			next_q.sync1 = capture_compare_pin_i;
			next_q.sync2 = q.sync1;
			next_q.sync3 = q.sync2;
			if (pin_stable) begin
				next_q.pin_lvl = q.sync3;
			end

			// Bus handshake: one wait state, then pready for one cycle
			next_q.pready = psel_i && penable_i && !q.pready;
			next_q.pslverr = psel_i && penable_i && !q.pready && !addr_ok;
			next_q.prdata = 32'h0000_0000;
			if (psel_i && penable_i && !q.pready) begin
				if (paddr_i == ADDR_VALUE_LOW) begin
					next_q.prdata = {24'h00_0000, q.val_lo};
				end else if (paddr_i == ADDR_VALUE_HIGH) begin
					next_q.prdata = {24'h00_0000, q.val_hi};
				end else if (paddr_i == ADDR_UNIT_CONTROL) begin
					next_q.prdata = {24'h00_0000, q.ctl};
				end else if (paddr_i == ADDR_EVENT_STATUS) begin
					next_q.prdata = {31'h0000_0000, q.flag};
				end
			end

			// Register writes
			if (wr_en && paddr_i == ADDR_VALUE_LOW) begin
				next_q.val_lo = pwdata_i[7:0];
			end
			if (wr_en && paddr_i == ADDR_VALUE_HIGH) begin
				next_q.val_hi = pwdata_i[7:0];
			end
			if (wr_en && paddr_i == ADDR_UNIT_CONTROL) begin
				next_q.ctl = pwdata_i[7:0];
				if (pwdata_i[7:0] == CTL_RESET) begin
					next_q.cmp_latch = 1'b0;
				end
			end

			// Prescaler: held at zero outside capture, counts rising edges in
			// the divided modes; a direct prescaler change keeps the count
			if (!is_cap) begin
				next_q.pres = 4'h0;
			end else if (mode[1] && pin_rise) begin
				next_q.pres = cap_fire ? 4'h0 : q.pres + 4'h1;
			end

			// Capture overwrites any pending value and beats a bus write
			if (cap_fire) begin
				next_q.val_lo = timer_one_count_i[7:0];
				next_q.val_hi = timer_one_count_i[15:8];
			end

			// Compare pin action, taken on the same edge as the flag
			if (match) begin
				unique case (mode)
					MODE_CMP_TOGGLE: next_q.cmp_latch = !q.cmp_latch;
					MODE_CMP_SET: next_q.cmp_latch = 1'b1;
					MODE_CMP_CLEAR: next_q.cmp_latch = 1'b0;
					default: next_q.cmp_latch = q.cmp_latch;
				endcase
			end
			if (mode == MODE_OFF) begin
				next_q.cmp_latch = 1'b0;
			end

			// Special event: clear timer one and request a conversion. Only
			// the clear strobe leaves here, so the overflow flag is untouched
			next_q.tmr_clear = match && (mode == MODE_CMP_SPECIAL);
			next_q.adc_start = match && (mode == MODE_CMP_SPECIAL) && adc_enable_i;

			// Event flag: hardware set wins over a software clear
			next_q.flag = (q.flag && !flag_clr) || cap_fire || match;

			// Pin steering; outside PWM output A belongs to the unit in compare modes only, no other pin ever
			next_q.out_b = 1'b0;
			next_q.out_c = 1'b0;
			next_q.out_d = 1'b0;
			if (!is_pwm) begin
				next_q.own = {3'b000, is_cmp};
				next_q.out_a = q.cmp_latch;
			end else begin
				unique case (steer)
					STEER_SINGLE: next_q.own = 4'h1;
					STEER_HALF: next_q.own = 4'h3;
					default: next_q.own = 4'hF;
				endcase
				next_q.out_a = drv[0] ^ mode[1];
				next_q.out_b = (drv[1] ^ mode[0]) && steer != STEER_SINGLE;
				next_q.out_c = (drv[2] ^ mode[1]) && steer[0];
				next_q.out_d = (drv[3] ^ mode[0]) && steer[0];
			end

			// Duty cycle: the byte as upper eight bits, control bits as the low two
			next_q.duty = {q.val_lo, q.ctl[CTL_DUTY_LSB +: 2]};
		end
	end

	// State register
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
			q.ctl <= CTL_RESET;
			q.val_lo <= VALUE_RESET;
			q.val_hi <= VALUE_RESET;
		end else begin
			q <= next_q;
		end
	end

	// Outputs straight from the state register
	assign pready_o = q.pready;
	assign prdata_o = q.prdata;
	assign pslverr_o = q.pslverr;
	assign timer_one_clear_o = q.tmr_clear;
	assign adc_start_o = q.adc_start;
	assign pwm_output_a_o = q.out_a;
	assign pwm_output_b_o = q.out_b;
	assign pwm_output_c_o = q.out_c;
	assign pwm_output_d_o = q.out_d;
	assign pin_owned_o = q.own;
	assign duty_cycle_o = q.duty;
	assign unit_event_flag_o = q.flag;

	// Checks on the unit's own behaviour
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	chk_flag_sticky: assert property (
		ce_i && q.flag && !flag_clr |=> q.flag)
		else $error("event flag dropped without a software clear");

	chk_capture_copy: assert property (
		ce_i && cap_fire |=> {q.val_hi, q.val_lo} == $past(timer_one_count_i) && q.flag)
		else $error("capture did not copy the timer count");

	chk_special_event: assert property (
		ce_i && match && mode == MODE_CMP_SPECIAL
		|=> q.tmr_clear && q.flag && (q.adc_start == $past(adc_enable_i)))
		else $error("special event did not clear the timer");

	chk_compare_set: assert property (
		ce_i && match && mode == MODE_CMP_SET |=> q.cmp_latch ##1 !$past(ce_i) || q.out_a)
		else $error("set-on-match did not raise the output");

	chk_compare_clear: assert property (
		ce_i && match && mode == MODE_CMP_CLEAR |=> !q.cmp_latch && q.flag)
		else $error("clear-on-match did not lower the output");

	chk_soft_only: assert property (
		ce_i && mode == MODE_CMP_SOFT && !wr_en |=> $stable(q.cmp_latch))
		else $error("software-event mode moved the compare latch");

	chk_pres_clear: assert property (
		ce_i && !is_cap |=> q.pres == 4'h0)
		else $error("prescaler not cleared outside capture");

	chk_ctl_zero: assert property (
		wr_en && paddr_i == ADDR_UNIT_CONTROL && pwdata_i[7:0] == 8'h00
		|=> !q.cmp_latch && mode == MODE_OFF)
		else $error("zero control write left the latch high");

	chk_steer_ignored: assert property (
		ce_i && !is_pwm |=> q.own[3:1] == 3'b000 && !q.out_b && !q.out_c && !q.out_d)
		else $error("steering acted outside PWM modes");

	chk_prescale_16: assert property (
		ce_i && mode == MODE_CAP_RISE16 && pin_rise && q.pres < PRE16_LAST
		|=> q.pres == $past(q.pres) + 4'h1)
		else $error("divide-by-16 prescaler did not count");

	// Pulses and single events must not smear into a second cycle
	chk_pready_pulse: assert property (
		ce_i && q.pready |=> !q.pready)
		else $error("bus ready held for more than one cycle");

	chk_single_event: assert property (
		ce_i && pin_rise |=> !pin_rise)
		else $error("one pin edge produced two events");

	// Compare side: every match raises the flag, toggle flips the latch
	chk_flag_on_match: assert property (
		ce_i && match |=> q.flag)
		else $error("compare match did not set the event flag");

	chk_compare_toggle: assert property (
		ce_i && match && mode == MODE_CMP_TOGGLE
		|=> q.cmp_latch != $past(q.cmp_latch) && q.flag)
		else $error("toggle-on-match did not flip the output");

	chk_adc_gated: assert property (
		ce_i && !adc_enable_i |=> !q.adc_start)
		else $error("conversion started while the converter was off");

	// Switching the unit off must leave nothing armed behind
	chk_off_clears: assert property (
		ce_i && mode == MODE_OFF |=> !q.cmp_latch && q.pres == 4'h0)
		else $error("unit off but latch or prescaler not cleared");

	// In capture the pin is an input, so the unit claims no output
	chk_capture_input: assert property (
		ce_i && is_cap |=> q.own == 4'h0)
		else $error("capture mode claimed an output pin");

	// Bridge steering: pins claimed per code, A and C opposite in forward and reverse
	chk_single_out: assert property (
		ce_i && is_pwm && steer == STEER_SINGLE
		|=> q.own == 4'h1 && !q.out_b && !q.out_c && !q.out_d)
		else $error("single output drove a bridge pin");

	chk_half_bridge: assert property (
		ce_i && is_pwm && steer == STEER_HALF
		|=> q.own == 4'h3 && !q.out_c && !q.out_d)
		else $error("half bridge claimed the wrong pins");

	chk_full_bridge: assert property (
		ce_i && is_pwm && steer[0]
		|=> q.own == 4'hF && q.out_a != q.out_c)
		else $error("full bridge did not drive A and C apart");

endmodule

//--- ccu_timer_model.sv
`timescale 1ns/1ns
// Stand-in for timer one: counts on the core clock and restarts on the unit's clear pulse
module ccu_timer_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic clear_i,
	output logic [15:0] count_o,
	output logic tick_o
);
	// Synchronous counting only, since an asynchronous count is not guaranteed to be seen
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_o <= 16'h0000;
			tick_o <= 1'b0;
		end else if (clear_i) begin
			count_o <= 16'h0000;
			tick_o <= 1'b1;
		end else begin
			count_o <= count_o + {15'h0000, run_i};
			tick_o <= run_i;
		end
	end
endmodule

//--- tb_capture_compare_unit.sv
`timescale 1ns/1ns
module tb_capture_compare_unit;
	import ccu_pkg::*;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pin = 0, run = 0;
	logic adc_en = 1, mod = 1;
	logic [7:0] paddr = 8'h00, r;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, clr, adc, a, b, c, d, flag, tick, err;
	logic [3:0] owned;
	logic [9:0] duty;
	logic [15:0] cnt, v;
	int n_mismatch = 0, compares = 0;
	logic [3:0] own_exp [4] = '{4'h1, 4'hF, 4'h3, 4'hF};
	ccu_top ccu_top_inst (.core_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(4'hF), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
		.timer_one_count_i(cnt), .timer_one_tick_i(tick), .timer_one_clear_o(clr),
		.adc_enable_i(adc_en), .adc_start_o(adc), .capture_compare_pin_i(pin), .pwm_mod_i(mod),
		.pwm_output_a_o(a), .pwm_output_b_o(b), .pwm_output_c_o(c), .pwm_output_d_o(d),
		.pin_owned_o(owned), .duty_cycle_o(duty), .unit_event_flag_o(flag));
	ccu_timer_model ccu_timer_model_inst (.clk_i(clk), .rst_i(rst), .run_i(run),
		.clear_i(clr), .count_o(cnt), .tick_o(tick));
	// Free-running core clock, 8 ns period
	always #4 clk = ~clk;
	task tally_and_finish;
		$display("comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// A wait that used up its bound ends the run through the report
	task give_up(input int spent, input int limit);
		if (spent >= limit) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask
	task check(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			n_mismatch++;
		end
	endtask
	// One APB transfer; the request is held until pready is seen high at an edge
	task apb(input logic w, input logic [7:0] ad, input logic [7:0] dat);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= {24'h000000, dat};
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		r = prdata[7:0];
		err = pslverr;
		give_up(k, 20);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Compare run: timer frozen while set up, then released until the match flags
	// Only defined mode codes are ever programmed, never a reserved one
	task cmp(input logic [3:0] mode, input logic exp_a);
		int k;
		run <= 1'b0;
		apb(1, ADDR_EVENT_STATUS, 8'h01);
		v = cnt + 16'h0018;
		apb(1, ADDR_VALUE_HIGH, v[15:8]);
		apb(1, ADDR_VALUE_LOW, v[7:0]);
		apb(1, ADDR_UNIT_CONTROL, {4'h0, mode});
		check("flag before match", 16'h0, flag);
		run <= 1'b1;
		for (k = 0; k < 100 && flag !== 1'b1; k++)
			@(posedge clk);
		give_up(k, 100);
		check("flag on match", 16'h1, flag);
		repeat (3) @(posedge clk);
		check("compare output", exp_a, a);
	endtask
	task capture_and_compare(input string what);
		repeat (8) @(posedge clk);
		check(what, 16'h1, flag);
		apb(0, ADDR_VALUE_LOW, 8'h00);
		check("captured low", cnt[7:0], r);
		apb(0, ADDR_VALUE_HIGH, 8'h00);
		check("captured high", cnt[15:8], r);
	endtask
	initial begin
		int i;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		apb(0, ADDR_UNIT_CONTROL, 8'hFF);
		check("control reset", 16'h0, r);
		apb(0, ADDR_VALUE_LOW, 8'hFF);
		check("low reset", 16'h0, r);
		apb(1, ADDR_UNIT_CONTROL, 8'h30);
		apb(0, ADDR_UNIT_CONTROL, 8'h00);
		check("control rw", 16'h30, r);
		apb(0, 8'h00, 8'h00);
		check("unmapped error", 16'h1, err);
		$display("test registers done");
		cmp(MODE_CMP_SET, 1'b1);
		cmp(MODE_CMP_CLEAR, 1'b0);
		cmp(MODE_CMP_SOFT, 1'b0);
		cmp(MODE_CMP_TOGGLE, 1'b1);
		run <= 1'b0;
		apb(1, ADDR_EVENT_STATUS, 8'h01);
		v = cnt + 16'h0010;
		apb(1, ADDR_VALUE_HIGH, v[15:8]);
		apb(1, ADDR_VALUE_LOW, v[7:0]);
		apb(1, ADDR_UNIT_CONTROL, {4'h0, MODE_CMP_SPECIAL});
		run <= 1'b1;
		for (i = 0; i < 100 && clr !== 1'b1; i++)
			@(posedge clk);
		give_up(i, 100);
		check("timer clear", 16'h1, clr);
		check("conversion start", 16'h1, adc);
		repeat (2) @(posedge clk);
		check("timer restarted", 16'h1, cnt < 16'h0004);
		// The stored value now acts as the timer period; the next pass runs
		// with the converter disabled and must still clear the timer
		adc_en <= 1'b0;
		for (i = 0; i < 300 && clr !== 1'b1; i++)
			@(posedge clk);
		give_up(i, 300);
		check("period clear", 16'h1, clr);
		check("no start when disabled", 16'h0, adc);
		adc_en <= 1'b1;
		apb(1, ADDR_UNIT_CONTROL, 8'h00);
		repeat (2) @(posedge clk);
		check("latch after zero", 16'h0, a);
		$display("test compare done");
		run <= 1'b0;
		apb(1, ADDR_UNIT_CONTROL, {4'h0, MODE_CAP_RISE});
		apb(1, ADDR_EVENT_STATUS, 8'h01);
		pin <= 1'b1;
		capture_and_compare("flag after rise");
		pin <= 1'b0;
		run <= 1'b1;
		repeat (5) @(posedge clk);
		run <= 1'b0;
		repeat (8) @(posedge clk);
		check("flag stays set", 16'h1, flag);
		pin <= 1'b1;
		capture_and_compare("flag after second rise");
		apb(1, ADDR_UNIT_CONTROL, 8'h00);
		apb(1, ADDR_UNIT_CONTROL, {4'h0, MODE_CAP_RISE4});
		pin <= 1'b0;
		repeat (8) @(posedge clk);
		apb(1, ADDR_EVENT_STATUS, 8'h01);
		for (i = 1; i <= 4; i++) begin
			pin <= 1'b1;
			repeat (4) @(posedge clk);
			pin <= 1'b0;
			repeat (8) @(posedge clk);
			check("flag on fourth rise", i == 4, flag);
		end
		apb(1, ADDR_UNIT_CONTROL, 8'h00);
		apb(1, ADDR_UNIT_CONTROL, {4'h0, MODE_CAP_FALL});
		apb(1, ADDR_EVENT_STATUS, 8'h01);
		pin <= 1'b1;
		repeat (8) @(posedge clk);
		check("no flag on rise", 16'h0, flag);
		pin <= 1'b0;
		repeat (8) @(posedge clk);
		check("flag on fall", 16'h1, flag);
		$display("test capture done");
		apb(1, ADDR_VALUE_LOW, 8'hA5);
		for (i = 0; i < 4; i++) begin
			apb(1, ADDR_UNIT_CONTROL, {i[1:0], 6'h3C});
			repeat (3) @(posedge clk);
			check("pins owned", own_exp[i], owned);
		end
		check("duty", 10'h297, duty);
		apb(1, ADDR_UNIT_CONTROL, 8'h4C);
		repeat (3) @(posedge clk);
		check("forward outputs", 4'b1001, {a, b, c, d});
		mod <= 1'b0;
		repeat (3) @(posedge clk);
		check("forward modulated", 4'b1000, {a, b, c, d});
		mod <= 1'b1;
		apb(1, ADDR_UNIT_CONTROL, 8'h4F);
		repeat (3) @(posedge clk);
		check("inverted outputs", 4'b0110, {a, b, c, d});
		apb(1, ADDR_UNIT_CONTROL, 8'h48);
		repeat (3) @(posedge clk);
		check("steering ignored", 16'h1, owned);
		$display("test steering done");
		tally_and_finish();
	end
endmodule
